/* design/bsp_sequencer.sv */
// Holds the start-up, switching and protection sequencer of a synchronous buck controller.
// Assumes comparator outputs arrive asynchronously and ocs_level_code comes from a
// converter clocked by sys_clk; ramp and threshold codes feed converters outside.
`timescale 1ns/1ps

// How it works
// - Stay off until the supply-good comparator reports supply above its rising threshold.
// - Enable comparator rising while active starts a soft-start cycle.
// - Enable node held low by outside transistor keeps the block shut down.
// - Charge source on enable node runs whenever supply is good, also while the node is held low, up to the ceiling.
// - Charge source switches off when the node exceeds the ceiling.
// - Regulation target is the lower of reference and rising ramp.
// - Soft-start ends at ramp 1.3 times reference; voltage checks start then.
// - Initialise and capture overcurrent limit before the ramp starts.
// - At first high-side turn-on, low switch node aborts the soft-start.
// - After a missing-input abort, wait 6 ms and retry soft-start.
// - High-side on-time capped at 90 percent of each period.
// - Switch node below negative threshold while low side on in ramp or run trips overcurrent.
// - Programmed threshold is one quarter of the set pin voltage.
// - Feedback above 125 percent of reference trips overvoltage.
// - After soft-start, feedback below 30 percent of reference trips undervoltage.
// - Undervoltage turns both gates off; overvoltage holds low side on.
// - Voltage trips latch until supply reset or enable toggled low.
// - Enable node low stops switching and holds both gates low.
// - A gate turns on only after the other gate is sensed off.
// - Switching runs at a fixed 300 kHz period.
// - Overvoltage must persist 20 us before the trip acts.
module bsp_sequencer #(
  parameter int RETRY_CYC_P      = bsp_pkg::RETRY_CYC,
  parameter int RAMP_STEP_CYC_P  = bsp_pkg::RAMP_STEP_CYC,
  parameter bit PROGRAMMABLE_OCP = 1'b1
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire bsp_pkg::bsp_comp_t          comp_in,
  input  wire logic [bsp_pkg::CODE_W-1:0]  ocs_level_code,
  output logic                             high_side_gate,
  output logic                             low_side_gate,
  output logic                             overcurrent_trip,
  output logic                             overvoltage_trip,
  output logic                             undervoltage_trip,
  output logic                             soft_start_done,
  output logic                             enable_source_on,
  output logic                             ocs_source_on,
  output logic [bsp_pkg::CODE_W-1:0]       target_code,
  output logic [bsp_pkg::CODE_W-1:0]       ocp_threshold_code
);

  // ----------------------------------------------------------------------
  // Constants at working widths
  // ----------------------------------------------------------------------
  localparam logic [bsp_pkg::TMR_W-1:0] INIT_LAST  = bsp_pkg::TMR_W'(bsp_pkg::INIT_CYC - 1);
  localparam logic [bsp_pkg::TMR_W-1:0] RETRY_LAST = bsp_pkg::TMR_W'(RETRY_CYC_P - 1);
  localparam logic [bsp_pkg::TMR_W-1:0] STEP_LAST  =
    bsp_pkg::TMR_W'(RAMP_STEP_CYC_P - 1);
  localparam logic [bsp_pkg::PWM_W-1:0] PWM_LAST   =
    bsp_pkg::PWM_W'(bsp_pkg::PWM_PERIOD_CYC - 1);
  localparam logic [bsp_pkg::PWM_W-1:0] MAX_ON     = bsp_pkg::PWM_W'(bsp_pkg::MAX_ON_CYC);
  localparam logic [bsp_pkg::OV_W-1:0]  OV_LAST    =
    bsp_pkg::OV_W'(bsp_pkg::OV_DELAY_CYC - 1);
  localparam logic [bsp_pkg::DET_W-1:0] DET_LAST   =
    bsp_pkg::DET_W'(bsp_pkg::DET_DELAY_CYC - 1);

  localparam bsp_pkg::bsp_state_t RESET_STATE = '{
    st:         bsp_pkg::ST_OFF,
    tmr:        '0,
    pwm_cnt:    '0,
    ov_cnt:     '0,
    det_cnt:    '0,
    first_done: 1'b0,
    ramp:       bsp_pkg::ZERO_CODE,
    tgt:        bsp_pkg::ZERO_CODE,
    ocp_thr:    bsp_pkg::FIXED_OCP_CODE,
    hsg:        1'b0,
    lsg:        1'b0,
    oc_trip:    1'b0,
    ov_trip:    1'b0,
    uv_trip:    1'b0,
    ss_done:    1'b0,
    ocs_src:    1'b0,
    en_src:     1'b0
  };

  // ----------------------------------------------------------------------
  // Comparator synchronisation
  // ----------------------------------------------------------------------
  bsp_pkg::bsp_comp_t comp_s;
  logic [bsp_pkg::COMP_W-1:0] comp_s_vec;

  bsp_sync #(
    .W (bsp_pkg::COMP_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (comp_in),
    .sync_out (comp_s_vec)
  );

  assign comp_s = bsp_pkg::bsp_comp_t'(comp_s_vec);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bsp_pkg::bsp_state_t q_ff;
  bsp_pkg::bsp_state_t nxt_q;

  logic switching;
  logic hs_req;
  logic ls_req;

  always_comb begin
    nxt_q     = q_ff;
    switching = 1'b0;
    hs_req    = 1'b0;
    ls_req    = 1'b0;

    unique case (q_ff.st)
      bsp_pkg::ST_OFF: begin
        if (comp_s.supply_good) begin
          nxt_q.st = bsp_pkg::ST_SHUT;
        end
      end
      bsp_pkg::ST_SHUT: begin
        if (comp_s.enable_high) begin
          nxt_q.st      = bsp_pkg::ST_INIT;
          nxt_q.tmr     = '0;
          nxt_q.ocs_src = PROGRAMMABLE_OCP;
        end
      end
      bsp_pkg::ST_INIT: begin
        nxt_q.tmr = q_ff.tmr + 1'b1;
        if (q_ff.tmr == INIT_LAST) begin
          if (PROGRAMMABLE_OCP) begin
            nxt_q.ocp_thr = ocs_level_code >> bsp_pkg::OCS_DIV_SHIFT;
          end else begin
            nxt_q.ocp_thr = bsp_pkg::FIXED_OCP_CODE;
          end
          nxt_q.ocs_src    = 1'b0;
          nxt_q.st         = bsp_pkg::ST_RAMP;
          nxt_q.tmr        = '0;
          nxt_q.ramp       = bsp_pkg::ZERO_CODE;
          nxt_q.first_done = 1'b0;
          nxt_q.det_cnt    = '0;
        end
      end
      bsp_pkg::ST_RAMP: begin
        nxt_q.tmr = q_ff.tmr + 1'b1;
        if (q_ff.tmr == STEP_LAST) begin
          nxt_q.tmr  = '0;
          nxt_q.ramp = q_ff.ramp + 1'b1;
        end
        if (q_ff.ramp >= bsp_pkg::SS_END_CODE) begin
          nxt_q.st      = bsp_pkg::ST_RUN;
          nxt_q.ramp    = q_ff.ramp;
          nxt_q.ss_done = 1'b1;
        end
        if (!q_ff.first_done && q_ff.hsg) begin
          nxt_q.det_cnt = q_ff.det_cnt + 1'b1;
          if (q_ff.det_cnt == DET_LAST) begin
            nxt_q.first_done = 1'b1;
            if (!comp_s.switch_high) begin
              nxt_q.st  = bsp_pkg::ST_RETRY;
              nxt_q.tmr = '0;
            end
          end
        end
      end
      bsp_pkg::ST_RUN: begin
        if (comp_s.fb_over) begin
          nxt_q.ov_cnt = q_ff.ov_cnt + 1'b1;
          if (q_ff.ov_cnt == OV_LAST) begin
            nxt_q.ov_trip = 1'b1;
            nxt_q.st      = bsp_pkg::ST_LATCH;
          end
        end else begin
          nxt_q.ov_cnt = '0;
        end
        if (comp_s.fb_under) begin
          nxt_q.uv_trip = 1'b1;
          nxt_q.st      = bsp_pkg::ST_LATCH;
        end
      end
      bsp_pkg::ST_RETRY: begin
        nxt_q.tmr = q_ff.tmr + 1'b1;
        if (q_ff.tmr == RETRY_LAST) begin
          nxt_q.st      = bsp_pkg::ST_INIT;
          nxt_q.tmr     = '0;
          nxt_q.ocs_src = PROGRAMMABLE_OCP;
        end
      end
      bsp_pkg::ST_LATCH: begin
        nxt_q.st = bsp_pkg::ST_LATCH;
      end
      default: begin
        nxt_q.st = bsp_pkg::ST_OFF;
      end
    endcase

    // Overcurrent is watched while the low side conducts in ramp or run.
    if ((q_ff.st == bsp_pkg::ST_RAMP || q_ff.st == bsp_pkg::ST_RUN) &&
        q_ff.lsg && comp_s.switch_below_ocp) begin
      nxt_q.oc_trip = 1'b1;
      nxt_q.st      = bsp_pkg::ST_LATCH;
    end

    // Enable low or supply loss shuts down and clears every latch.
    if (!comp_s.supply_good) begin
      nxt_q    = RESET_STATE;
    end else if (!comp_s.enable_high && q_ff.st != bsp_pkg::ST_OFF) begin
      nxt_q.st      = bsp_pkg::ST_SHUT;
      nxt_q.oc_trip = 1'b0;
      nxt_q.ov_trip = 1'b0;
      nxt_q.uv_trip = 1'b0;
      nxt_q.ss_done = 1'b0;
      nxt_q.ocs_src = 1'b0;
      nxt_q.ramp    = bsp_pkg::ZERO_CODE;
      nxt_q.ov_cnt  = '0;
    end

    // ----------------------------------------------------------------------
    // Gate drive
    // ----------------------------------------------------------------------
    switching = (nxt_q.st == bsp_pkg::ST_RAMP) || (nxt_q.st == bsp_pkg::ST_RUN);
    if (switching) begin
      nxt_q.pwm_cnt = (q_ff.pwm_cnt == PWM_LAST) ? '0 : q_ff.pwm_cnt + 1'b1;
    end else begin
      nxt_q.pwm_cnt = '0;
    end
    hs_req = switching && comp_s.pwm_on && (q_ff.pwm_cnt < MAX_ON);
    ls_req = (switching && !hs_req) ||
             (nxt_q.st == bsp_pkg::ST_LATCH && nxt_q.ov_trip);
    nxt_q.hsg = hs_req && comp_s.ls_gate_low && !q_ff.lsg;
    nxt_q.lsg = ls_req && comp_s.hs_gate_low && !q_ff.hsg;

    // ----------------------------------------------------------------------
    // Source enables and target
    // ----------------------------------------------------------------------
    nxt_q.en_src = comp_s.supply_good && !comp_s.comp_above_ceiling;
    nxt_q.tgt    = (nxt_q.ramp < bsp_pkg::REF_CODE) ? nxt_q.ramp : bsp_pkg::REF_CODE;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_ff <= RESET_STATE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign high_side_gate     = q_ff.hsg;
  assign low_side_gate      = q_ff.lsg;
  assign overcurrent_trip   = q_ff.oc_trip;
  assign overvoltage_trip   = q_ff.ov_trip;
  assign undervoltage_trip  = q_ff.uv_trip;
  assign soft_start_done    = q_ff.ss_done;
  assign enable_source_on   = q_ff.en_src;
  assign ocs_source_on      = q_ff.ocs_src;
  assign target_code        = q_ff.tgt;
  assign ocp_threshold_code = q_ff.ocp_thr;

endmodule

/* design/bsp_sync.sv */
// Holds a two-flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; multi-bit words are not kept coherent.
`timescale 1ns/1ps
module bsp_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bsp_sync_state_t;

  bsp_sync_state_t q_ff;
  bsp_sync_state_t nxt_q;

  // ----------------------------------------------------------------------
  // Two stages; only the second stage is read outside.
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_q    = q_ff;
    nxt_q.s1 = async_in;
    nxt_q.s2 = q_ff.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sync_out = q_ff.s2;

endmodule

/* pkg/bsp_pkg.sv */
// Holds the constants, types and state layout of the buck start-up protection sequencer.
// Assumes a 25 MHz sys_clk and analog comparators and converters outside this logic.
package bsp_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int PWM_FREQ_KHZ   = 300;
  localparam int PWM_PERIOD_CYC = 1000000 / (PWM_FREQ_KHZ * CLK_PERIOD_NS);
  localparam int MAX_DUTY_PCT   = 90;
  localparam int MAX_ON_CYC     = PWM_PERIOD_CYC * MAX_DUTY_PCT / 100;
  localparam int OV_DELAY_NS    = 20000;
  localparam int OV_DELAY_CYC   = (OV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_MS       = 6;
  localparam int RETRY_CYC      = RETRY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int INIT_US        = 100;
  localparam int INIT_CYC       = INIT_US * 1000 / CLK_PERIOD_NS;
  localparam int RAMP_STEP_CYC  = 104;
  localparam int DET_DELAY_CYC  = 4;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int CODE_W = 10;
  localparam int TMR_W  = 18;
  localparam int PWM_W  = 7;
  localparam int OV_W   = 9;
  localparam int DET_W  = 3;

  // ----------------------------------------------------------------------
  // Levels in millivolt codes
  // ----------------------------------------------------------------------
  localparam int REF_MV      = 600;
  localparam int SS_END_NUM  = 13;
  localparam int SS_END_DEN  = 10;
  localparam logic [CODE_W-1:0] REF_CODE    = CODE_W'(REF_MV);
  localparam logic [CODE_W-1:0] SS_END_CODE = CODE_W'(REF_MV * SS_END_NUM / SS_END_DEN);
  localparam logic [CODE_W-1:0] FIXED_OCP_CODE = CODE_W'(300);
  localparam int OCS_DIV_SHIFT = 2;
  localparam logic [CODE_W-1:0] ZERO_CODE = 10'h000;

  // ----------------------------------------------------------------------
  // Comparator inputs
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic supply_good;
    logic enable_high;
    logic comp_above_ceiling;
    logic switch_high;
    logic switch_below_ocp;
    logic fb_over;
    logic fb_under;
    logic pwm_on;
    logic hs_gate_low;
    logic ls_gate_low;
  } bsp_comp_t;

  localparam int COMP_W = $bits(bsp_comp_t);

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_OFF   = 7'h01,
    ST_SHUT  = 7'h02,
    ST_INIT  = 7'h04,
    ST_RAMP  = 7'h08,
    ST_RUN   = 7'h10,
    ST_RETRY = 7'h20,
    ST_LATCH = 7'h40
  } bsp_state_e_t;

  typedef struct packed {
    bsp_state_e_t        st;
    logic [TMR_W-1:0]    tmr;
    logic [PWM_W-1:0]    pwm_cnt;
    logic [OV_W-1:0]     ov_cnt;
    logic [DET_W-1:0]    det_cnt;
    logic                first_done;
    logic [CODE_W-1:0]   ramp;
    logic [CODE_W-1:0]   tgt;
    logic [CODE_W-1:0]   ocp_thr;
    logic                hsg;
    logic                lsg;
    logic                oc_trip;
    logic                ov_trip;
    logic                uv_trip;
    logic                ss_done;
    logic                ocs_src;
    logic                en_src;
  } bsp_state_t;

endpackage

/* verification/bsp_power_stage.sv */
// Power stage, compensation node and enable pull-down around the sequencer.
// Assumes the bench sets the analog conditions; the PWM demand is always full.
`timescale 1ns/1ps
module bsp_power_stage (
  input  wire logic         sys_clk,
  input  wire logic         high_side_gate,
  input  wire logic         low_side_gate,
  input  wire logic         enable_source_on,
  input  wire logic         soft_start_done,
  input  wire logic         supply_on,
  input  wire logic         pull_low,
  input  wire logic         vin_on,
  input  wire logic         oc_on,
  input  wire logic         fb_over_in,
  input  wire logic         fb_under_in,
  output bsp_pkg::bsp_comp_t comp_in
);
  logic [10:0] comp_mv;
  logic        hs_on;
  logic        ls_on;
  initial begin
    comp_mv = 11'h000;
    hs_on = 1'b0;
    ls_on = 1'b0;
  end
  // Gates are sensed one cycle late; the node charges 10 mV a cycle.
  always @(posedge sys_clk) begin
    hs_on <= high_side_gate;
    ls_on <= low_side_gate;
    if (pull_low) begin
      comp_mv <= 11'h000;
    end else if (soft_start_done) begin
      comp_mv <= 11'h44C;
    end else if (enable_source_on && comp_mv < 11'h3E8) begin
      comp_mv <= comp_mv + 11'h00A;
    end
  end
  always_comb begin
    comp_in.supply_good        = supply_on;
    comp_in.enable_high        = comp_mv > 11'h12C;
    comp_in.comp_above_ceiling = comp_mv > 11'h3E8;
    comp_in.switch_high        = hs_on && vin_on;
    comp_in.switch_below_ocp   = ls_on && oc_on;
    comp_in.fb_over            = fb_over_in;
    comp_in.fb_under           = fb_under_in;
    comp_in.pwm_on             = 1'b1;
    comp_in.hs_gate_low        = !hs_on;
    comp_in.ls_gate_low        = !ls_on;
  end
endmodule

/* verification/bsp_sequencer_properties.sv */
// Concurrent checks on the sequencer ports, bound into every sequencer instance.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module bsp_sequencer_properties (
  input wire logic                       sys_clk,
  input wire logic                       rst,
  input wire bsp_pkg::bsp_comp_t         comp_in,
  input wire logic [bsp_pkg::CODE_W-1:0] ocs_level_code,
  input wire logic                       high_side_gate,
  input wire logic                       low_side_gate,
  input wire logic                       overcurrent_trip,
  input wire logic                       overvoltage_trip,
  input wire logic                       undervoltage_trip,
  input wire logic                       soft_start_done,
  input wire logic                       enable_source_on,
  input wire logic                       ocs_source_on,
  input wire logic [bsp_pkg::CODE_W-1:0] target_code,
  input wire logic [bsp_pkg::CODE_W-1:0] ocp_threshold_code
);
  // ----
  // Run-length counters
  // ----
  logic [9:0] hs_run_ff;
  logic [9:0] nxt_hs_run;
  logic [9:0] ov_run_ff;
  logic [9:0] nxt_ov_run;
  always_comb begin
    nxt_hs_run = high_side_gate ? hs_run_ff + 10'h001 : 10'h000;
    nxt_ov_run = comp_in.fb_over ? ov_run_ff + 10'h001 : 10'h000;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hs_run_ff <= 10'h000;
      ov_run_ff <= 10'h000;
    end else begin
      hs_run_ff <= nxt_hs_run;
      ov_run_ff <= nxt_ov_run;
    end
  end
  // ----
  // Assertions and cover points
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  no_overlap_a: assert property (!(high_side_gate && low_side_gate))
    else $error("both gates on");
  gate_order_a: assert property ($rose(high_side_gate) |-> !$past(low_side_gate))
    else $error("high side on while low side was on");
  max_duty_a: assert property (hs_run_ff <= 10'(bsp_pkg::MAX_ON_CYC))
    else $error("high side on too long");
  en_low_off_a: assert property ((!comp_in.enable_high) [*5] |->
    !high_side_gate && !low_side_gate && !overvoltage_trip && !overcurrent_trip)
    else $error("activity while enable low");
  supply_off_a: assert property ((!comp_in.supply_good) [*5] |->
    !high_side_gate && !low_side_gate && !soft_start_done && !ocs_source_on)
    else $error("activity without supply");
  uv_gates_a: assert property (undervoltage_trip && $past(undervoltage_trip) |->
    !high_side_gate && !low_side_gate) else $error("gate on during undervoltage");
  ov_gates_a: assert property ($rose(overvoltage_trip) |->
    ##[0:6] (low_side_gate && !high_side_gate)) else $error("overvoltage gate state");
  ov_delay_a: assert property ($rose(overvoltage_trip) |->
    ov_run_ff >= 10'(bsp_pkg::OV_DELAY_CYC)) else $error("overvoltage acted early");
  ss_gate_a: assert property ($rose(overvoltage_trip) || $rose(undervoltage_trip) |->
    $past(soft_start_done)) else $error("voltage trip before soft-start end");
  target_cap_a: assert property (target_code <= bsp_pkg::REF_CODE &&
    (!soft_start_done || target_code == bsp_pkg::REF_CODE)) else $error("target wrong");
  charge_ceiling_a: assert property (comp_in.comp_above_ceiling [*5] |-> !enable_source_on)
    else $error("charge source on above ceiling");
  oc_cause_a: assert property ($rose(overcurrent_trip) |-> $past(low_side_gate))
    else $error("overcurrent without low side on");
  ss_c: cover property ($rose(soft_start_done));
  oc_c: cover property ($rose(overcurrent_trip));
  ov_c: cover property ($rose(overvoltage_trip));
  init_c: cover property ($rose(ocs_source_on));
  uv_c: cover property ($rose(undervoltage_trip));
endmodule

bind bsp_sequencer bsp_sequencer_properties u_props (
  .sys_clk(sys_clk), .rst(rst), .comp_in(comp_in), .ocs_level_code(ocs_level_code),
  .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
  .overcurrent_trip(overcurrent_trip), .overvoltage_trip(overvoltage_trip),
  .undervoltage_trip(undervoltage_trip), .soft_start_done(soft_start_done),
  .enable_source_on(enable_source_on), .ocs_source_on(ocs_source_on),
  .target_code(target_code), .ocp_threshold_code(ocp_threshold_code)
);

/* verification/bsp_sequencer_tb.sv */
// Self-checking bench for the sequencer with a power-stage model on its far side.
// Assumes the package, the sequencer and the power-stage model are compiled first.
`timescale 1ns/1ps
module bsp_sequencer_tb;
  logic                       sys_clk = 1'b0;
  logic                       rst = 1'b1;
  logic                       supply_on = 1'b0;
  logic                       pull_low = 1'b0;
  logic                       vin_on = 1'b0;
  logic                       oc_on = 1'b0;
  logic                       fb_over_in = 1'b0;
  logic                       fb_under_in = 1'b0;
  logic [bsp_pkg::CODE_W-1:0] ocs_code = 10'h3E8;
  logic [bsp_pkg::CODE_W-1:0] tgt;
  logic [bsp_pkg::CODE_W-1:0] thr;
  bsp_pkg::bsp_comp_t         comp_in;
  logic                       hsg;
  logic                       lsg;
  logic                       oc_t;
  logic                       ov_t;
  logic                       uv_t;
  logic                       ss_done;
  logic                       en_src;
  logic                       ocs_src;
  int                         n_fail = 0;
  int                         tests_run = 0;
  localparam int              RAMP_STEP = 8;
  localparam int              SS_MIN = bsp_pkg::INIT_CYC + int'(bsp_pkg::SS_END_CODE) * RAMP_STEP;

  always #20 sys_clk = ~sys_clk;

  bsp_sequencer #(.RETRY_CYC_P(200), .RAMP_STEP_CYC_P(RAMP_STEP), .PROGRAMMABLE_OCP(1'b1)) dut (
    .sys_clk(sys_clk), .rst(rst), .comp_in(comp_in), .ocs_level_code(ocs_code),
    .high_side_gate(hsg), .low_side_gate(lsg), .overcurrent_trip(oc_t),
    .overvoltage_trip(ov_t), .undervoltage_trip(uv_t), .soft_start_done(ss_done),
    .enable_source_on(en_src), .ocs_source_on(ocs_src), .target_code(tgt),
    .ocp_threshold_code(thr));
  bsp_power_stage u_stage (
    .sys_clk(sys_clk), .high_side_gate(hsg), .low_side_gate(lsg),
    .enable_source_on(en_src), .soft_start_done(ss_done), .supply_on(supply_on),
    .pull_low(pull_low), .vin_on(vin_on), .oc_on(oc_on), .fb_over_in(fb_over_in),
    .fb_under_in(fb_under_in), .comp_in(comp_in));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return hsg;
      1: return oc_t;
      2: return ov_t;
      3: return ss_done;
      default: return ocs_src;
    endcase
  endfunction

  task automatic wait_hi(input int k, input int lim, output int n);
    for (n = 0; n < lim && pick(k) !== 1'b1; n++) @(posedge sys_clk);
    if (n >= lim) begin
      chk(10'h000, 10'h001);
      close_out();
    end
  endtask

  task automatic t_power();
    repeat (40) @(posedge sys_clk);
    chk({8'h00, hsg, lsg}, 10'h000);
    chk({9'h000, en_src}, 10'h000);
    pull_low <= 1'b1;
    supply_on <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk({9'h000, en_src}, 10'h001);
    chk({7'h00, hsg, lsg, ocs_src}, 10'h000);
  endtask

  task automatic t_retry();
    int   n;
    logic quiet;
    quiet = 1'b1;
    ocs_code <= 10'h3E8;
    pull_low <= 1'b0;
    wait_hi(4, 100, n);
    wait_hi(0, 2700, n);
    chk({9'h000, n >= bsp_pkg::INIT_CYC}, 10'h001);
    chk({9'h000, ocs_src}, 10'h000);
    chk(thr, 10'h0FA);
    for (n = 0; n < 400 && ocs_src !== 1'b1; n++) begin
      @(posedge sys_clk);
      if (n > 12 && (hsg !== 1'b0 || lsg !== 1'b0)) quiet = 1'b0;
    end
    chk({9'h000, quiet}, 10'h001);
    chk({9'h000, n >= 200 && n < 220}, 10'h001);
  endtask

  task automatic t_ovc();
    int n;
    vin_on <= 1'b1;
    oc_on <= 1'b1;
    wait_hi(1, 3000, n);
    repeat (5) @(posedge sys_clk);
    chk({8'h00, hsg, lsg}, 10'h000);
    repeat (100) @(posedge sys_clk);
    chk({9'h000, oc_t}, 10'h001);
    pull_low <= 1'b1;
    oc_on <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({9'h000, oc_t}, 10'h000);
  endtask

  task automatic t_softstart();
    int   n;
    logic ok;
    ok = 1'b1;
    fb_under_in <= 1'b1;
    pull_low <= 1'b0;
    for (n = 0; n < 12000 && ss_done !== 1'b1; n++) begin
      @(posedge sys_clk);
      if (n == 4000) fb_under_in <= 1'b0;
      if (tgt > bsp_pkg::REF_CODE || uv_t !== 1'b0) ok = 1'b0;
    end
    if (n >= 12000) wait_hi(3, 1, n);
    chk({9'h000, ok}, 10'h001);
    chk({9'h000, n >= SS_MIN && n < SS_MIN + 100}, 10'h001);
    chk(tgt, bsp_pkg::REF_CODE);
    repeat (20) @(posedge sys_clk);
    chk({9'h000, en_src}, 10'h000);
    chk({8'h00, uv_t, ov_t}, 10'h000);
  endtask

  task automatic t_ov();
    int n;
    fb_over_in <= 1'b1;
    repeat (300) @(posedge sys_clk);
    fb_over_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({9'h000, ov_t}, 10'h000);
    fb_over_in <= 1'b1;
    wait_hi(2, 700, n);
    chk({9'h000, n >= 500 && n < 508}, 10'h001);
    repeat (10) @(posedge sys_clk);
    chk({8'h00, lsg, hsg}, 10'h002);
    pull_low <= 1'b1;
    fb_over_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({7'h00, ov_t, lsg, hsg}, 10'h000);
  endtask

  task automatic t_uv();
    int n;
    fb_under_in <= 1'b1;
    pull_low <= 1'b0;
    wait_hi(3, 12000, n);
    chk({9'h000, uv_t}, 10'h000);
    repeat (6) @(posedge sys_clk);
    chk({6'h00, uv_t, ov_t, hsg, lsg}, 10'h008);
    pull_low <= 1'b1;
    fb_under_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({9'h000, uv_t}, 10'h000);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_power();
    t_retry();
    t_ovc();
    t_softstart();
    t_ov();
    t_uv();
    close_out();
  end
endmodule
